// [rtl/pca_regs_map.vh]
`ifndef PCA_REGS_MAP_VH
`define PCA_REGS_MAP_VH

// Register indices; byte address on the bus is four times the index
`define CNT_LOW_IDX 8'hF9
`define CNT_HIGH_IDX 8'hFA
`define CAP0_LOW_IDX 8'hFB
`define CAP0_HIGH_IDX 8'hFC
`define CAP1_LOW_IDX 8'hE9
`define CAP1_HIGH_IDX 8'hEA
`define CAP2_LOW_IDX 8'hEB
`define CAP2_HIGH_IDX 8'hEC
`define CAP3_LOW_IDX 8'hED
`define CAP3_HIGH_IDX 8'hEE
`define CAP4_LOW_IDX 8'hFD
`define CAP4_HIGH_IDX 8'hFE
`define CTRL_IDX 8'h80
`define ENABLE_IDX 8'h81

// Control register field positions
`define CTRL_WDOG_BIT 0
`define CTRL_RUN_BIT 1
`define CTRL_RELOAD_SEL_BIT 7

// Number of capture/compare modules
`define MOD_COUNT 5

// Reset values
`define BYTE_RESET 8'h00
`define WORD_RESET 16'h0000
`define ENABLE_RESET 5'h00

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/sfr_index_decode.v]
`timescale 1ns/10ps
`default_nettype none
`include "pca_regs_map.vh"

module sfr_index_decode (
  input wire [7:0] index,
  input wire in_range,
  output wire hit_cnt_low,
  output wire hit_cnt_high,
  output wire hit_ctrl,
  output wire hit_enable,
  output wire [4:0] hit_cap_low,
  output wire [4:0] hit_cap_high,
  output wire mapped
);
  localparam [39:0] LOW_IDX = {`CAP4_LOW_IDX, `CAP3_LOW_IDX,
    `CAP2_LOW_IDX, `CAP1_LOW_IDX, `CAP0_LOW_IDX};
  localparam [39:0] HIGH_IDX = {`CAP4_HIGH_IDX, `CAP3_HIGH_IDX,
    `CAP2_HIGH_IDX, `CAP1_HIGH_IDX, `CAP0_HIGH_IDX};
  genvar g;

  // Plain register hits
  assign hit_cnt_low = in_range && (index == `CNT_LOW_IDX);
  assign hit_cnt_high = in_range && (index == `CNT_HIGH_IDX);
  assign hit_ctrl = in_range && (index == `CTRL_IDX);
  assign hit_enable = in_range && (index == `ENABLE_IDX);

  // One compare per module byte
  generate
    for (g = 0; g < `MOD_COUNT; g = g + 1) begin : mod_hit
      assign hit_cap_low[g] = in_range && (index == LOW_IDX[8*g+7:8*g]);
      assign hit_cap_high[g] = in_range && (index == HIGH_IDX[8*g+7:8*g]);
    end
  endgenerate

  assign mapped = hit_cnt_low | hit_cnt_high | hit_ctrl | hit_enable |
    (|hit_cap_low) | (|hit_cap_high);
endmodule
`default_nettype wire

// [rtl/capture_module_bank.v]
`timescale 1ns/10ps
`default_nettype none
`include "pca_regs_map.vh"

module capture_module_bank (
  input wire aclk,
  input wire aresetn,
  input wire wr_en,
  input wire [4:0] wr_low_hit,
  input wire [4:0] wr_high_hit,
  input wire [7:0] wr_data,
  input wire auto_reload_select,
  input wire enable_load,
  input wire [4:0] enable_data,
  input wire [4:0] rd_low_hit,
  input wire [4:0] rd_high_hit,
  output wire [7:0] rd_byte,
  output wire [79:0] compare_value,
  output wire [79:0] reload_value,
  output wire [4:0] compare_enable
);
  wire [7:0] partial [0:`MOD_COUNT];
  genvar g;

  assign partial[0] = `BYTE_RESET;

  generate
    for (g = 0; g < `MOD_COUNT; g = g + 1) begin : chan
      reg [15:0] cap;
      reg [15:0] rel;
      reg ecom;
      wire [7:0] low_view;
      wire [7:0] high_view;

      // Only one address is written per cycle, so no branches collide
      always @(posedge aclk) begin
        if (!aresetn) begin
          cap <= `WORD_RESET;
          rel <= `WORD_RESET;
          ecom <= 1'b0;
        end else if (wr_en) begin
          if (wr_low_hit[g]) begin
            if (auto_reload_select)
              rel[7:0] <= wr_data;
            else
              cap[7:0] <= wr_data;
            ecom <= 1'b0;
          end else if (wr_high_hit[g]) begin
            if (auto_reload_select)
              rel[15:8] <= wr_data;
            else
              cap[15:8] <= wr_data;
            ecom <= 1'b1;
          end else if (enable_load) begin
            ecom <= enable_data[g];
          end
        end
      end

      assign low_view = auto_reload_select ? rel[7:0] : cap[7:0];
      assign high_view = auto_reload_select ? rel[15:8] : cap[15:8];
      assign partial[g+1] = partial[g] |
        ({8{rd_low_hit[g]}} & low_view) |
        ({8{rd_high_hit[g]}} & high_view);
      assign compare_value[16*g+15:16*g] = cap;
      assign reload_value[16*g+15:16*g] = rel;
      assign compare_enable[g] = ecom;
    end
  endgenerate

  assign rd_byte = partial[`MOD_COUNT];
endmodule
`default_nettype wire

// [rtl/pca_counter_capture_regs.v]
`timescale 1ns/10ps
`default_nettype none
`include "pca_regs_map.vh"

// Overview of operation
// - Counter is one 16-bit value, low byte 0xF9, high 0xFA, reset zero.
// - High byte read returns snapshot, refreshed only on low byte read.
// - Watchdog enable set blocks software writes to counter low byte.
// - Watchdog enable set blocks software writes to counter high byte.
// - Five modules own 16-bit values; low bytes at 0xFB,E9,EB,ED,FD.
// - Module high bytes at 0xFC,EA,EC,EE,FE, read/write, reset zero.
// - Same addresses alternatively reach each module's auto-reload value.
// - Writing a module low byte clears its comparator enable.
// - Writing a module high byte sets its comparator enable.
// - Selector 0 reaches capture registers, 1 reaches auto-reload ones.
// - Comparator enable high turns that module's comparator on.

module pca_counter_capture_regs #(
  parameter ADDR_W = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [15:0] array_counter,
  output wire [79:0] capture_compare_value,
  output wire [79:0] reload_value,
  output wire [4:0] comparator_function_enable,
  output reg watchdog_enable,
  output reg auto_reload_select,
  output reg count_run
);
  // Held write channel contents
  reg [ADDR_W-1:0] aw_addr;
  reg aw_held;
  reg [7:0] w_byte;
  reg w_lane0;
  reg w_held;
  // High byte copy handed out on high byte reads
  reg [7:0] snapshot;

  wire do_write;
  wire wr_range;
  wire rd_range;
  wire wr_cnt_low;
  wire wr_cnt_high;
  wire wr_ctrl;
  wire wr_enable;
  wire [4:0] wr_cap_low;
  wire [4:0] wr_cap_high;
  wire wr_mapped;
  wire rd_cnt_low;
  wire rd_cnt_high;
  wire rd_ctrl;
  wire rd_enable;
  wire [4:0] rd_cap_low;
  wire [4:0] rd_cap_high;
  wire rd_mapped;
  wire [7:0] bank_byte;
  wire bank_wr;
  wire ar_take;
  reg [7:0] next_rd_byte;
  reg [15:0] next_array_counter;
  reg [7:0] ctrl_view;
  // Side-effect strobes of the write or read carried out this cycle
  wire cnt_low_store;
  wire cnt_high_store;
  wire ctrl_store;
  wire snap_load;

  // Write fires once address and data are both held and no answer waits
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  // Lanes other than byte 0 carry nothing; a write without it is dropped
  assign bank_wr = do_write && w_lane0;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // A locked counter write is still answered OKAY and changes nothing;
  // software must clear the lock bit first, as no error is reported
  // low byte write lock
  assign cnt_low_store = bank_wr && wr_cnt_low && !watchdog_enable;
  assign cnt_high_store = bank_wr && wr_cnt_high && !watchdog_enable;
  // The lock never guards the control byte, or it could not be undone
  assign ctrl_store = bank_wr && wr_ctrl;
  // copy rides on the low byte read
  assign snap_load = ar_take && rd_cnt_low;

  // Address bits above the index window must be zero to hit a register
  assign wr_range = (aw_addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) &&
    (aw_addr[1:0] == 2'b00);
  assign rd_range = (s_axi_araddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}}) &&
    (s_axi_araddr[1:0] == 2'b00);

  // Decode for the held write address
  sfr_index_decode wr_decode (
    .index(aw_addr[9:2]),
    .in_range(wr_range),
    .hit_cnt_low(wr_cnt_low),
    .hit_cnt_high(wr_cnt_high),
    .hit_ctrl(wr_ctrl),
    .hit_enable(wr_enable),
    .hit_cap_low(wr_cap_low),
    .hit_cap_high(wr_cap_high),
    .mapped(wr_mapped)
  );

  // Decode for the offered read address
  sfr_index_decode rd_decode (
    .index(s_axi_araddr[9:2]),
    .in_range(rd_range),
    .hit_cnt_low(rd_cnt_low),
    .hit_cnt_high(rd_cnt_high),
    .hit_ctrl(rd_ctrl),
    .hit_enable(rd_enable),
    .hit_cap_low(rd_cap_low),
    .hit_cap_high(rd_cap_high),
    .mapped(rd_mapped)
  );

  // Capture/compare and auto-reload storage of the five modules
  capture_module_bank bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(bank_wr),
    .wr_low_hit(wr_cap_low),
    .wr_high_hit(wr_cap_high),
    .wr_data(w_byte),
    .auto_reload_select(auto_reload_select),
    .enable_load(wr_enable),
    .enable_data(w_byte[4:0]),
    .rd_low_hit(rd_cap_low),
    .rd_high_hit(rd_cap_high),
    .rd_byte(bank_byte),
    .compare_value(capture_compare_value),
    .reload_value(reload_value),
    .compare_enable(comparator_function_enable)
  );

  // Write address channel; one write in flight at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= {ADDR_W{1'b0}};
      aw_held <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, accepted independently of the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_byte <= `BYTE_RESET;
      w_lane0 <= 1'b0;
      w_held <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer with a slave error
  // and a write without the lane 0 strobe is answered but stores nothing
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control bits: watchdog lock, count run and storage selector
  always @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_enable <= 1'b0;
      count_run <= 1'b0;
      auto_reload_select <= 1'b0;
    end else if (ctrl_store) begin
      watchdog_enable <= w_byte[`CTRL_WDOG_BIT];
      count_run <= w_byte[`CTRL_RUN_BIT];
      auto_reload_select <= w_byte[`CTRL_RELOAD_SEL_BIT];
    end
  end

  // Next counter value: a software write wins over the count for that
  // cycle, so the other byte keeps its value and no count is added
  always @* begin
    next_array_counter = array_counter;
    if (cnt_low_store) begin
      // low byte of the one value
      next_array_counter[7:0] = w_byte;
    end else if (cnt_high_store) begin
      // high byte of the one value
      next_array_counter[15:8] = w_byte;
    end else if (count_run) begin
      next_array_counter = array_counter + 16'h0001;
    end
  end

  // Counter register
  always @(posedge aclk) begin
    if (!aresetn) begin
      array_counter <= `WORD_RESET;
    end else begin
      array_counter <= next_array_counter;
    end
  end

  // Snapshot of the high byte, taken only on a low byte read
  always @(posedge aclk) begin
    if (!aresetn) begin
      snapshot <= `BYTE_RESET;
    end else if (snap_load) begin
      snapshot <= array_counter[15:8];
    end
  end

  // Control byte as software reads it back; unused bits read zero
  always @* begin
    ctrl_view = `BYTE_RESET;
    ctrl_view[`CTRL_WDOG_BIT] = watchdog_enable;
    ctrl_view[`CTRL_RUN_BIT] = count_run;
    ctrl_view[`CTRL_RELOAD_SEL_BIT] = auto_reload_select;
  end

  // Read data selection for the offered address
  always @* begin
    next_rd_byte = `BYTE_RESET;
    if (rd_cnt_low) begin
      next_rd_byte = array_counter[7:0];
    end else if (rd_cnt_high) begin
      next_rd_byte = snapshot;
    end else if (rd_ctrl) begin
      next_rd_byte = ctrl_view;
    end else if (rd_enable) begin
      next_rd_byte = {3'b000, comparator_function_enable};
    end else begin
      next_rd_byte = bank_byte;
    end
  end

  // Read channel; data is captured on the address edge itself,
  // so the answer never waits on a second decode cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, next_rd_byte};
      s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [tb/pca_regs_chk_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module pca_regs_chk #(
  parameter ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] array_counter,
  input wire logic [4:0] comparator_function_enable,
  input wire logic watchdog_enable,
  input wire logic count_run
);
  logic [ADDR_W-1:0] wa;
  logic ws;
  // Latch target and strobe; aw and w may land on different edges
  always @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
  end
  wire cnt_hit = (wa == 'h3E4) || (wa == 'h3E8);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_LOW_CLR: assert property (
    $rose(s_axi_bvalid) && ws && wa == 'h3EC
    |-> !comparator_function_enable[0]) else $error("low write kept enable");
  AST_HIGH_SET: assert property (
    $rose(s_axi_bvalid) && ws && wa == 'h3F0
    |-> comparator_function_enable[0]) else $error("high write no enable");
  AST_WDOG_LOCK: assert property (
    $rose(s_axi_bvalid) && ws && watchdog_enable && !count_run && cnt_hit
    |-> $stable(array_counter)) else $error("locked counter changed");
  AST_CNT_STILL: assert property (
    !count_run && !$rose(s_axi_bvalid) |-> $stable(array_counter))
    else $error("counter moved by itself");
  AST_B_LAT: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  AST_AW_HOLD: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("awready back too soon");
  AST_R_LAT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  AST_RDATA_HI: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
endmodule
`default_nettype wire

// [tb/pca_counter_capture_regs_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pca_regs_map.vh"
module pca_counter_capture_regs_tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic arvalid = 0;
  logic [31:0] wdata = 0;
  wire awready, wready, bvalid, arready, rvalid, wdog, reload_sel, run;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] cnt;
  wire [79:0] ccv, rlv;
  wire [4:0] cfe;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  // Module low-byte indices; each high byte sits one above
  logic [7:0] lo [5] = '{8'hFB, 8'hE9, 8'hEB, 8'hED, 8'hFD};

  // Ready lines held high: legal, and keeps answers prompt
  pca_counter_capture_regs dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .array_counter(cnt), .capture_compare_value(ccv), .reload_value(rlv),
    .comparator_function_enable(cfe), .watchdog_enable(wdog),
    .auto_reload_select(reload_sel), .count_run(run));

  function automatic [11:0] ba(input [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic chk(input [31:0] g, input [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input [7:0] i, input [7:0] d);
    awaddr <= ba(i);
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
  endtask

  task automatic rdr(input [7:0] i);
    araddr <= ba(i);
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask

  task automatic rchk(input [7:0] i, input [7:0] e);
    rdr(i);
    chk(rd, {24'h000000, e});
    chk(rs, `RESP_OKAY);
  endtask

  task automatic t_reset;
    for (int m = 0; m < 5; m++) begin
      rchk(lo[m], 8'h00);
      rchk(lo[m] + 8'h01, 8'h00);
    end
    rchk(8'hF9, 8'h00);
    rchk(8'hFA, 8'h00);
  endtask

  // High, low, high again per module; the others must not move
  task automatic t_cap;
    logic [4:0] e;
    logic [7:0] k;
    e = 5'h00;
    for (int m = 0; m < 5; m++) begin
      k = 8'(m);
      wr(lo[m] + 8'h01, k + 8'h50);
      e[m] = 1'b1;
      chk(cfe, e);
      wr(lo[m], k + 8'h60);
      e[m] = 1'b0;
      chk(cfe, e);
      wr(lo[m] + 8'h01, k + 8'h50);
      e[m] = 1'b1;
      chk(cfe, e);
    end
    for (int m = 0; m < 5; m++) begin
      k = 8'(m);
      rchk(lo[m], k + 8'h60);
      rchk(lo[m] + 8'h01, k + 8'h50);
    end
  endtask

  task automatic t_reload;
    logic [7:0] k;
    wr(`CTRL_IDX, 8'h80);
    chk(reload_sel, 1'b1);
    rchk(`CTRL_IDX, 8'h80);
    for (int m = 0; m < 5; m++) begin
      k = 8'(m);
      wr(lo[m], k + 8'hA0);
      wr(lo[m] + 8'h01, k + 8'hB0);
      chk(rlv[16*m +: 16], {k + 8'hB0, k + 8'hA0});
      rchk(lo[m], k + 8'hA0);
    end
    wr(`CTRL_IDX, 8'h00);
    chk(reload_sel, 1'b0);
    for (int m = 0; m < 5; m++) begin
      k = 8'(m);
      rchk(lo[m], k + 8'h60);
      chk(ccv[16*m +: 16], {k + 8'h50, k + 8'h60});
    end
  endtask

  // Counter writes bounce while the watchdog is armed
  task automatic t_cnt;
    wr(8'hF9, 8'hFF);
    wr(8'hFA, 8'h12);
    chk(cnt, 16'h12FF);
    wr(`CTRL_IDX, 8'h01);
    chk(wdog, 1'b1);
    wr(8'hF9, 8'h00);
    chk(rs, `RESP_OKAY);
    chk(cnt, 16'h12FF);
    wr(8'hFA, 8'h00);
    chk(cnt, 16'h12FF);
    wr(`CTRL_IDX, 8'h00);
    chk(wdog, 1'b0);
  endtask

  task automatic t_snap;
    rchk(8'hFA, 8'h00);
    rchk(8'hF9, 8'hFF);
    wr(8'hFA, 8'h34);
    rchk(8'hFA, 8'h12);
    rchk(8'hF9, 8'hFF);
    rchk(8'hFA, 8'h34);
  endtask

  // Enable byte loads all five bits; the counter then runs for three
  // edges: the answer edge, the next address edge and the stop write
  task automatic t_run;
    wr(`ENABLE_IDX, 8'h15);
    chk(cfe, 5'h15);
    rchk(`ENABLE_IDX, 8'h15);
    wr(`CTRL_IDX, 8'h02);
    chk(run, 1'b1);
    wr(`CTRL_IDX, 8'h00);
    chk(run, 1'b0);
    chk(cnt, 16'h3502);
  endtask

  task automatic t_unmap;
    rdr(8'h00);
    chk(rs, `RESP_SLVERR);
    chk(rd, 32'h00000000);
    wr(8'h00, 8'h55);
    chk(rs, `RESP_SLVERR);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    forever #4 aclk = ~aclk;
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_cap;
    t_reload;
    t_cnt;
    t_snap;
    t_run;
    t_unmap;
    final_report;
  end

  // Whole run needs a few hundred cycles; far more means a hang
  initial begin
    #200000;
    error_cnt++;
    final_report;
  end
endmodule

bind pca_counter_capture_regs pca_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire
